// file: efp_cfg.svh
// timing, width and limit constants for the user flash controller
`ifndef EFP_CFG_SVH
`define EFP_CFG_SVH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define EFP_COL_W 6
`define EFP_DATA_W 32
`define EFP_ROW_W 9
`define EFP_ROWS_LARGE 304
`define EFP_ROWS_SMALL 128
`define EFP_PAGE_ROW_BITS 3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EFP_CLK_PERIOD_NS 100
`define EFP_TPWS_NS 100
`define EFP_TNWS_NS 100
`define EFP_PROGRAM_STROBE_TIME_US 16
`define EFP_ERASE_TIME_MS 120
`define EFP_TPWS_CYC ((`EFP_TPWS_NS + `EFP_CLK_PERIOD_NS - 1) / `EFP_CLK_PERIOD_NS)
`define EFP_TNWS_CYC ((`EFP_TNWS_NS + `EFP_CLK_PERIOD_NS - 1) / `EFP_CLK_PERIOD_NS)
`define EFP_PROGRAM_STROBE_CYC ((`EFP_PROGRAM_STROBE_TIME_US * 1000 + `EFP_CLK_PERIOD_NS - 1) / `EFP_CLK_PERIOD_NS)
`define EFP_ERASE_CYC ((`EFP_ERASE_TIME_MS * 1000000 + `EFP_CLK_PERIOD_NS - 1) / `EFP_CLK_PERIOD_NS)
`define EFP_SYNC_CYC 2
`define EFP_TMR_W 21

`endif

// file: efp_pkg.sv
// types shared by the user flash controller
package efp_pkg;

  // ----------------------------------------------------------------
  // user commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EFP_OP_READ = 2'h0,
    EFP_OP_PROGRAM = 2'h1,
    EFP_OP_ERASE = 2'h2,
    EFP_OP_NONE = 2'h3
  } efp_op_e;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EFP_ST_IDLE = 3'b000,
    EFP_ST_RD_LOW = 3'b001,
    EFP_ST_RD_HIGH = 3'b010,
    EFP_ST_RD_WAIT = 3'b011,
    EFP_ST_PROGRAM_STROBE = 3'b100,
    EFP_ST_ERASE = 3'b101,
    EFP_ST_RECOVER = 3'b110
  } efp_state_e;

  // ----------------------------------------------------------------
  // flash control strobes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic row_addr_en;
    logic col_addr_en;
    logic sense_amp_en;
    logic program_strobe;
    logic erase_strobe;
    logic store_strobe;
  } efp_strobes_s;

endpackage

// file: efp_timer.sv
// loadable down counter that times flash phases
module efp_timer #(
  parameter int W = 21
) (
  // clocking
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // status
  output logic done
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  // one count left means this cycle closes the phase
  assign done = (cnt_reg == {{(W-1){1'b0}}, 1'b1}) || (cnt_reg == '0);

endmodule

// file: efp_ctrl.sv
// controller that drives the user flash strobe port from a command port
`include "efp_cfg.svh"

module efp_ctrl #(
  parameter int ROW_W = `EFP_ROW_W,
  parameter int ROWS = `EFP_ROWS_LARGE,
  parameter int PROGRAM_STROBE_CYC = `EFP_PROGRAM_STROBE_CYC,
  parameter int ERASE_CYC = `EFP_ERASE_CYC
) (
  // clocking
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // user command
  input wire logic cmd_valid,
  input wire efp_pkg::efp_op_e cmd_op,
  input wire logic [ROW_W-1:0] cmd_row,
  input wire logic [`EFP_COL_W-1:0] cmd_col,
  input wire logic [`EFP_DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  // user answer
  output logic rsp_valid,
  output logic rsp_err,
  output logic [`EFP_DATA_W-1:0] rsp_rdata,
  // flash pins
  output logic [ROW_W-1:0] row_addr,
  output logic [`EFP_COL_W-1:0] col_addr,
  output logic [`EFP_DATA_W-1:0] flash_din,
  output efp_pkg::efp_strobes_s flash_ctl,
  input wire logic [`EFP_DATA_W-1:0] flash_dout
);

  localparam int TW = `EFP_TMR_W;

  // ----------------------------------------------------------------
  // read data synchroniser
  // ----------------------------------------------------------------
  logic [`EFP_DATA_W-1:0] dout_meta_reg;
  logic [`EFP_DATA_W-1:0] dout_sync_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dout_meta_reg <= '0;
      dout_sync_reg <= '0;
    end else if (ce) begin
      dout_meta_reg <= flash_dout;
      dout_sync_reg <= dout_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  efp_pkg::efp_state_e state_reg;
  efp_pkg::efp_state_e state_next;
  efp_pkg::efp_strobes_s ctl_reg;
  efp_pkg::efp_strobes_s ctl_next;
  logic [ROW_W-1:0] row_reg;
  logic [ROW_W-1:0] row_next;
  logic [`EFP_COL_W-1:0] col_reg;
  logic [`EFP_COL_W-1:0] col_next;
  logic [`EFP_DATA_W-1:0] din_reg;
  logic [`EFP_DATA_W-1:0] din_next;
  logic [`EFP_DATA_W-1:0] rdata_reg;
  logic [`EFP_DATA_W-1:0] rdata_next;
  logic rsp_valid_reg;
  logic rsp_valid_next;
  logic rsp_err_reg;
  logic rsp_err_next;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;
  logic row_ok;

  assign row_ok = (32'(cmd_row) < 32'(ROWS));
  assign cmd_ready = (state_reg == efp_pkg::EFP_ST_IDLE);

  always_comb begin
    state_next = state_reg;
    ctl_next = ctl_reg;
    row_next = row_reg;
    col_next = col_reg;
    din_next = din_reg;
    rdata_next = rdata_reg;
    rsp_valid_next = 1'b0;
    rsp_err_next = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_reg)
      efp_pkg::EFP_ST_IDLE: begin
        ctl_next = '0;
        if (cmd_valid) begin
          if (!row_ok || cmd_op == efp_pkg::EFP_OP_NONE) begin
            rsp_valid_next = 1'b1;
            rsp_err_next = 1'b1;
          end else begin
            row_next = cmd_row;
            col_next = cmd_col;
            tmr_load = 1'b1;
            if (cmd_op == efp_pkg::EFP_OP_READ) begin
              ctl_next.row_addr_en = 1'b1;
              ctl_next.col_addr_en = 1'b1;
              tmr_val = TW'(`EFP_TNWS_CYC);
              state_next = efp_pkg::EFP_ST_RD_LOW;
            end else if (cmd_op == efp_pkg::EFP_OP_PROGRAM) begin
              din_next = cmd_wdata;
              ctl_next.row_addr_en = 1'b1;
              ctl_next.col_addr_en = 1'b1;
              ctl_next.program_strobe = 1'b1;
              ctl_next.store_strobe = 1'b1;
              tmr_val = TW'(PROGRAM_STROBE_CYC);
              state_next = efp_pkg::EFP_ST_PROGRAM_STROBE;
            end else begin
              // column field ignored: erase hits the whole page
              row_next = {cmd_row[ROW_W-1:`EFP_PAGE_ROW_BITS], `EFP_PAGE_ROW_BITS'(0)};
              ctl_next.row_addr_en = 1'b1;
              ctl_next.erase_strobe = 1'b1;
              ctl_next.store_strobe = 1'b1;
              tmr_val = TW'(ERASE_CYC);
              state_next = efp_pkg::EFP_ST_ERASE;
            end
          end
        end
      end
      efp_pkg::EFP_ST_RD_LOW: begin
        if (tmr_done) begin
          ctl_next.sense_amp_en = 1'b1;
          tmr_load = 1'b1;
          tmr_val = TW'(`EFP_TPWS_CYC);
          state_next = efp_pkg::EFP_ST_RD_HIGH;
        end
      end
      efp_pkg::EFP_ST_RD_HIGH: begin
        if (tmr_done) begin
          ctl_next.sense_amp_en = 1'b0;
          tmr_load = 1'b1;
          tmr_val = TW'(`EFP_SYNC_CYC + 1);
          state_next = efp_pkg::EFP_ST_RD_WAIT;
        end
      end
      efp_pkg::EFP_ST_RD_WAIT: begin
        // word sensed in the high phase has now crossed both sync stages
        if (tmr_done) begin
          rdata_next = dout_sync_reg;
          rsp_valid_next = 1'b1;
          ctl_next = '0;
          state_next = efp_pkg::EFP_ST_RECOVER;
        end
      end
      efp_pkg::EFP_ST_PROGRAM_STROBE, efp_pkg::EFP_ST_ERASE: begin
        if (tmr_done) begin
          ctl_next = '0;
          rsp_valid_next = 1'b1;
          state_next = efp_pkg::EFP_ST_RECOVER;
        end
      end
      efp_pkg::EFP_ST_RECOVER: begin
        // one idle cycle with every strobe low before the next command
        ctl_next = '0;
        state_next = efp_pkg::EFP_ST_IDLE;
      end
      default: begin
        ctl_next = '0;
        state_next = efp_pkg::EFP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= efp_pkg::EFP_ST_IDLE;
      ctl_reg <= '0;
      row_reg <= '0;
      col_reg <= '0;
      din_reg <= '0;
      rdata_reg <= '0;
      rsp_valid_reg <= 1'b0;
      rsp_err_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      ctl_reg <= ctl_next;
      row_reg <= row_next;
      col_reg <= col_next;
      din_reg <= din_next;
      rdata_reg <= rdata_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_err_reg <= rsp_err_next;
    end
  end

  efp_timer #(
    .W(TW)
  ) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign row_addr = row_reg;
  assign col_addr = col_reg;
  assign flash_din = din_reg;
  assign flash_ctl = ctl_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_err = rsp_err_reg;
  assign rsp_rdata = rdata_reg;

endmodule

// file: efp_ctrl_chk.sv
// checker on the user flash controller ports
module efp_ctrl_chk #(
  parameter int ROW_W = 9,
  parameter int ROWS = 304,
  parameter int PROGRAM_STROBE_CYC = 160,
  parameter int ERASE_CYC = 1200000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // user side
  input wire logic cmd_valid,
  input wire efp_pkg::efp_op_e cmd_op,
  input wire logic [ROW_W-1:0] cmd_row,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  // flash side
  input wire logic [ROW_W-1:0] row_addr,
  input wire efp_pkg::efp_strobes_s flash_ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn || !ce);
  // ------
  // store strobe high-time counter
  // ------
  efp_pkg::efp_strobes_s s;
  logic take;
  int hi_reg;
  int hi_next;
  assign s = flash_ctl;
  assign take = cmd_valid && cmd_ready;
  always_comb hi_next = !ce ? hi_reg : (s.store_strobe ? hi_reg + 1 : 0);
  always_ff @(posedge sys_clk) hi_reg <= !rstn ? 0 : hi_next;
  rd_mode_a: assert property (s.sense_amp_en |-> s == 6'h38)
    else $error("read strobes wrong");
  pg_mode_a: assert property (s.program_strobe |-> s == 6'h35)
    else $error("program strobes wrong");
  er_mode_a: assert property (s.erase_strobe |-> s == 6'h23 && row_addr[2:0] == 3'h0)
    else $error("erase strobes wrong");
  sense_pulse_a: assert property ($rose(s.sense_amp_en) |-> $past(s) == 6'h30 ##1 s == 6'h30)
    else $error("sense pulse wrong");
  pg_len_a: assert property ($fell(s.program_strobe) |-> hi_reg inside {[PROGRAM_STROBE_CYC:PROGRAM_STROBE_CYC+1]})
    else $error("program time wrong");
  er_len_a: assert property ($fell(s.erase_strobe) |-> hi_reg inside {[ERASE_CYC:ERASE_CYC+1]})
    else $error("erase time wrong");
  done_a: assert property (rsp_valid && !rsp_err |-> s == 6'h0 && !cmd_ready ##1 cmd_ready)
    else $error("recovery wrong");
  rd_lat_a: assert property (take && cmd_op == efp_pkg::EFP_OP_READ && cmd_row < ROWS
    |-> ##6 rsp_valid && !rsp_err) else $error("read latency wrong");
  refuse_a: assert property (take && (cmd_row >= ROWS || cmd_op == efp_pkg::EFP_OP_NONE)
    |=> rsp_valid && rsp_err && s == 6'h0) else $error("refusal wrong");
  hold_a: assert property (s.row_addr_en && $past(s.row_addr_en) |-> $stable(row_addr))
    else $error("row moved");
  cover property (rsp_valid && rsp_err);
  cover property ($fell(s.erase_strobe));
  cover property ($fell(s.program_strobe));
endmodule
bind efp_ctrl efp_ctrl_chk #(.ROW_W(ROW_W), .ROWS(ROWS), .PROGRAM_STROBE_CYC(PROGRAM_STROBE_CYC),
  .ERASE_CYC(ERASE_CYC)) u_efp_ctrl_chk (.sys_clk, .rstn, .ce, .cmd_valid, .cmd_op,
  .cmd_row, .cmd_ready, .rsp_valid, .rsp_err, .row_addr, .flash_ctl);

// file: efp_flash_model.sv
// behavioural user flash array; erased words read as all ones
module efp_flash_model (
  // clock
  input wire logic sys_clk,
  // flash pins
  input wire logic [8:0] row_addr,
  input wire logic [5:0] col_addr,
  input wire logic [31:0] flash_din,
  input wire efp_pkg::efp_strobes_s flash_ctl,
  output logic [31:0] flash_dout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:32767];
  logic [31:0] last = 32'h0;
  logic sel;
  assign sel = flash_ctl.row_addr_en && flash_ctl.col_addr_en;
  initial for (int k = 0; k < 32768; k++) mem[k] = 32'hffffffff;
  always @(posedge sys_clk) begin
    if (sel && flash_ctl.sense_amp_en) last <= mem[{row_addr, col_addr}];
    if (sel && flash_ctl.program_strobe && flash_ctl.store_strobe)
      mem[{row_addr, col_addr}] <= flash_din;
    if (flash_ctl.row_addr_en && flash_ctl.erase_strobe && flash_ctl.store_strobe)
      for (int k = 0; k < 512; k++) mem[{row_addr[8:3], k[8:0]}] <= 32'hffffffff;
  end
  // released data lines show the inverse of the last word
  assign flash_dout = sel ? last : ~last;
endmodule

// file: efp_ctrl_tb.sv
// testbench for the user flash controller with a behavioural array
module efp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, ce, cmd_valid, cmd_ready, rsp_valid, rsp_err;
  efp_pkg::efp_op_e cmd_op;
  logic [8:0] cmd_row, row_addr;
  logic [5:0] cmd_col, col_addr;
  logic [31:0] cmd_wdata, rsp_rdata, flash_din, flash_dout;
  efp_pkg::efp_strobes_s flash_ctl;
  int num_errors = 0;
  int n_compared = 0;
  efp_ctrl #(.PROGRAM_STROBE_CYC(20), .ERASE_CYC(50)) u_efp_ctrl (.sys_clk, .rstn, .ce, .cmd_valid,
    .cmd_op, .cmd_row, .cmd_col, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_err, .rsp_rdata,
    .row_addr, .col_addr, .flash_din, .flash_ctl, .flash_dout);
  efp_flash_model u_efp_flash_model (.sys_clk, .row_addr, .col_addr, .flash_din,
    .flash_ctl, .flash_dout);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic do_cmd(input efp_pkg::efp_op_e op, input logic [8:0] r, input logic [5:0] c,
                        input logic [31:0] d, input logic e, input logic [31:0] x);
    int n;
    logic rdy;
    cmd_op <= op;
    cmd_row <= r;
    cmd_col <= c;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      rdy = cmd_ready === 1'b1 && ce === 1'b1;
      @(posedge sys_clk);
    end while (!rdy && n < 300);
    cmd_valid <= 1'b0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 600);
    if (n >= 300 && !rdy || n >= 600) begin
      num_errors++;
      $display("FAIL %0t no answer", $time);
      test_done();
    end
    cmp1(rsp_err, e);
    if (op == efp_pkg::EFP_OP_READ && !e) cmp32(rsp_rdata, x);
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [8:0] r, input logic [5:0] c, input logic [31:0] x);
    do_cmd(efp_pkg::EFP_OP_READ, r, c, 32'h0, 1'b0, x);
  endtask
  task automatic pg(input logic [8:0] r, input logic [5:0] c, input logic [31:0] d);
    do_cmd(efp_pkg::EFP_OP_PROGRAM, r, c, d, 1'b0, 32'h0);
  endtask
  task automatic t_program_strobe_read();
    rd(9'h0, 6'h0, 32'hffffffff);
    pg(9'h5, 6'h3f, 32'ha5a50f0f);
    pg(9'h12f, 6'h0, 32'h12345678);
    pg(9'h8, 6'h1, 32'h0badf00d);
    rd(9'h5, 6'h3f, 32'ha5a50f0f);
    rd(9'h12f, 6'h0, 32'h12345678);
    rd(9'h8, 6'h1, 32'h0badf00d);
    rd(9'h5, 6'h3e, 32'hffffffff);
  endtask
  task automatic t_erase();
    do_cmd(efp_pkg::EFP_OP_ERASE, 9'h5, 6'h0, 32'h0, 1'b0, 32'h0);
    rd(9'h5, 6'h3f, 32'hffffffff);
    rd(9'h8, 6'h1, 32'h0badf00d);
  endtask
  task automatic t_refuse();
    do_cmd(efp_pkg::EFP_OP_READ, 9'h130, 6'h0, 32'h0, 1'b1, 32'h0);
    do_cmd(efp_pkg::EFP_OP_NONE, 9'h5, 6'h3f, 32'h0, 1'b1, 32'h0);
    do_cmd(efp_pkg::EFP_OP_PROGRAM, 9'h1ff, 6'h3f, 32'h1, 1'b1, 32'h0);
    rd(9'h5, 6'h3f, 32'hffffffff);
  endtask
  task automatic t_ce();
    fork
      pg(9'h40, 6'h20, 32'h13579bdf);
      begin
        repeat (4) @(posedge sys_clk);
        ce <= 1'b0;
        repeat (5) @(posedge sys_clk);
        ce <= 1'b1;
      end
    join
    rd(9'h40, 6'h20, 32'h13579bdf);
  endtask
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = efp_pkg::EFP_OP_NONE;
    cmd_row = 9'h0;
    cmd_col = 6'h0;
    cmd_wdata = 32'h0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_program_strobe_read();
    t_erase();
    t_refuse();
    t_ce();
    test_done();
  end
endmodule
